// >>> core/prsb_pkg.sv
// Purpose: Shared constants and types for the channel 0 loop status readback bank
// Assumes: Register indices are printed byte offsets; byte address is four times the index
// Notes:   All fields live in the low byte of each 32-bit APB word
package prsb_pkg;

    localparam int ADDR_W     = 16;
    localparam int IDX_W      = 14;
    localparam int IDX_LSB    = 2;
    localparam int DATA_W     = 32;
    localparam int BYTE_W     = 8;
    localparam int TW_W       = 46;
    localparam int ACC_W      = 12;
    localparam int PROF_W     = 3;
    localparam int SLEW_ERR_W = 4;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_LOCK    = 14'h3100;
    localparam logic [IDX_W-1:0] IDX_OPER    = 14'h3101;
    localparam logic [IDX_W-1:0] IDX_STATE   = 14'h3102;
    localparam logic [IDX_W-1:0] IDX_TW0     = 14'h3103;
    localparam logic [IDX_W-1:0] IDX_TW1     = 14'h3104;
    localparam logic [IDX_W-1:0] IDX_TW2     = 14'h3105;
    localparam logic [IDX_W-1:0] IDX_TW3     = 14'h3106;
    localparam logic [IDX_W-1:0] IDX_TW4     = 14'h3107;
    localparam logic [IDX_W-1:0] IDX_TW5     = 14'h3108;
    localparam logic [IDX_W-1:0] IDX_PLD_LO  = 14'h3109;
    localparam logic [IDX_W-1:0] IDX_PLD_HI  = 14'h310a;
    localparam logic [IDX_W-1:0] IDX_FLD_LO  = 14'h310b;
    localparam logic [IDX_W-1:0] IDX_FLD_HI  = 14'h310c;
    localparam logic [IDX_W-1:0] IDX_SLEW_ACT = 14'h310d;
    localparam logic [IDX_W-1:0] IDX_SLEW_ERR = 14'h310e;

    // Lock status bit positions
    localparam int LK_CAL_DONE = 5;
    localparam int LK_CAL_BUSY = 4;
    localparam int LK_ALOCK    = 3;
    localparam int LK_FLOCK    = 2;
    localparam int LK_PLOCK    = 1;
    localparam int LK_ALL      = 0;
    // Operation bit positions
    localparam int OP_PROF_LSB = 4;
    localparam int OP_ACTIVE   = 3;
    localparam int OP_REFSW    = 2;
    localparam int OP_HOLD     = 1;
    localparam int OP_FREERUN  = 0;
    // State bit positions
    localparam int ST_FAST_ACQUIRE_DONE = 5;
    localparam int ST_FAST_ACQUIRE_ACT  = 4;
    localparam int ST_SLEW_LIM  = 2;
    localparam int ST_FCLAMP    = 1;
    localparam int ST_HIST      = 0;

    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic                  analog_lock;
        logic                  dig_freq_lock;
        logic                  dig_phase_lock;
        logic                  dig_active;
        logic                  ref_switch;
        logic                  holdover;
        logic                  freerun;
        logic [PROF_W-1:0]     profile;
        logic                  fast_acquire_done;
        logic                  fast_acquire_active;
        logic                  slew_limit;
        logic                  freq_clamp;
        logic                  hist_avail;
        logic [TW_W-1:0]       tuning_hist;
        logic [ACC_W-1:0]      pld_accum;
        logic [ACC_W-1:0]      fld_accum;
        logic                  slew_active;
        logic [SLEW_ERR_W-1:0] slew_err;
    } prsb_loop_status_t;

    typedef enum logic [0:0] {
        PH_IDLE   = 1'b0,
        PH_ACCESS = 1'b1
    } prsb_phase_t;

    typedef struct packed {
        prsb_phase_t       phase;
        logic              cal_busy;
        logic              cal_done;
        logic [PROF_W-1:0] held_profile;
        logic              primed;
        prsb_loop_status_t snap;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } prsb_state_t;

endpackage

// >>> core/prsb_status_bank.sv
// Purpose: APB read-only status readback bank for loop channel 0
// Assumes: Loop status inputs come from logic on pclk; cal and update strobes are 1-cycle pulses
// Notes:   Lock byte is live, all other bytes are snapshots taken on io_update
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module prsb_status_bank (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [prsb_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [prsb_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [prsb_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire prsb_pkg::prsb_loop_status_t  loop_status,
    input  wire logic                         cal_issue,
    input  wire logic                         cal_complete,
    input  wire logic                         io_update
);

    prsb_pkg::prsb_state_t st_r;
    prsb_pkg::prsb_state_t st_nxt;

    logic [prsb_pkg::BYTE_W-1:0] lock_byte;
    logic                        setup_phase;
    logic [prsb_pkg::IDX_W-1:0]  req_idx;
    logic                        req_mapped;

    // Build the byte shown at one register index from live and snapshot values
    function automatic logic [prsb_pkg::BYTE_W:0] read_byte(
        input logic [prsb_pkg::IDX_W-1:0] idx,
        input logic [prsb_pkg::BYTE_W-1:0] live,
        input prsb_pkg::prsb_loop_status_t s
    );
        logic [prsb_pkg::BYTE_W-1:0] b;
        logic                        hit;
        b   = 8'h00;
        hit = 1'b1;
        case (idx)
            prsb_pkg::IDX_LOCK: begin
                b = live;
            end
            prsb_pkg::IDX_OPER: begin
                b[prsb_pkg::OP_PROF_LSB +: prsb_pkg::PROF_W] = s.profile;
                b[prsb_pkg::OP_ACTIVE]  = s.dig_active;
                b[prsb_pkg::OP_REFSW]   = s.ref_switch;
                b[prsb_pkg::OP_HOLD]    = s.holdover;
                b[prsb_pkg::OP_FREERUN] = s.freerun;
            end
            prsb_pkg::IDX_STATE: begin
                b[prsb_pkg::ST_FAST_ACQUIRE_DONE] = s.fast_acquire_done;
                b[prsb_pkg::ST_FAST_ACQUIRE_ACT]  = s.fast_acquire_active;
                b[prsb_pkg::ST_SLEW_LIM]  = s.slew_limit;
                b[prsb_pkg::ST_FCLAMP]    = s.freq_clamp;
                b[prsb_pkg::ST_HIST]      = s.hist_avail;
            end
            prsb_pkg::IDX_TW0: begin
                b = s.tuning_hist[7:0];
            end
            prsb_pkg::IDX_TW1: begin
                b = s.tuning_hist[15:8];
            end
            prsb_pkg::IDX_TW2: begin
                b = s.tuning_hist[23:16];
            end
            prsb_pkg::IDX_TW3: begin
                b = s.tuning_hist[31:24];
            end
            prsb_pkg::IDX_TW4: begin
                b = s.tuning_hist[39:32];
            end
            prsb_pkg::IDX_TW5: begin
                b[5:0] = s.tuning_hist[45:40];
            end
            prsb_pkg::IDX_PLD_LO: begin
                b = s.pld_accum[7:0];
            end
            prsb_pkg::IDX_PLD_HI: begin
                b[3:0] = s.pld_accum[11:8];
            end
            prsb_pkg::IDX_FLD_LO: begin
                b = s.fld_accum[7:0];
            end
            prsb_pkg::IDX_FLD_HI: begin
                b[3:0] = s.fld_accum[11:8];
            end
            // slew active in bit 0 only
            prsb_pkg::IDX_SLEW_ACT: begin
                b[0] = s.slew_active;
            end
            prsb_pkg::IDX_SLEW_ERR: begin
                b[prsb_pkg::SLEW_ERR_W-1:0] = s.slew_err;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return {hit, b};
    endfunction

    always_comb begin
        lock_byte = 8'h00;
        lock_byte[prsb_pkg::LK_CAL_DONE] = st_r.cal_done;
        lock_byte[prsb_pkg::LK_CAL_BUSY] = st_r.cal_busy;
        lock_byte[prsb_pkg::LK_ALOCK] = loop_status.analog_lock;
        lock_byte[prsb_pkg::LK_FLOCK] = loop_status.dig_freq_lock;
        lock_byte[prsb_pkg::LK_PLOCK] = loop_status.dig_phase_lock;
        lock_byte[prsb_pkg::LK_ALL] = loop_status.analog_lock & loop_status.dig_phase_lock;
    end

    assign setup_phase = psel && !penable;
    assign req_idx     = paddr[prsb_pkg::ADDR_W-1:prsb_pkg::IDX_LSB];

    always_comb begin
        logic [prsb_pkg::BYTE_W:0] rb;
        rb         = read_byte(req_idx, lock_byte, st_r.snap);
        req_mapped = rb[prsb_pkg::BYTE_W] && (paddr[prsb_pkg::IDX_LSB-1:0] == 2'b00);
        st_nxt     = st_r;

        // Calibration tracking, set wins over clear for done
        if (cal_issue) begin
            st_nxt.cal_busy = 1'b1;
        end else if (cal_complete) begin
            st_nxt.cal_busy = 1'b0;
        end
        if (cal_complete) begin
            st_nxt.cal_done = 1'b1;
        end else if (cal_issue) begin
            st_nxt.cal_done = 1'b0;
        end

        if (loop_status.dig_active) begin
            st_nxt.held_profile = loop_status.profile;
        end

        // first edge after reset loads live state
        if (io_update || !st_r.primed) begin
            st_nxt.snap   = loop_status;
            st_nxt.primed = 1'b1;
            if (!loop_status.dig_active) begin
                st_nxt.snap.profile = st_r.held_profile;
            end
        end

        // APB: data registered in setup, zero-wait access
        st_nxt.phase = setup_phase ? prsb_pkg::PH_ACCESS : prsb_pkg::PH_IDLE;
        if (setup_phase) begin
            st_nxt.pslverr = !req_mapped;
            // writes ignored, read data zero on writes
            if (!pwrite && req_mapped) begin
                st_nxt.prdata = {24'h00_0000, rb[prsb_pkg::BYTE_W-1:0]};
            end else begin
                st_nxt.prdata = prsb_pkg::RD_ZERO;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.prdata;
    assign pready  = 1'b1;
    assign pslverr = (st_r.phase == prsb_pkg::PH_ACCESS) ? st_r.pslverr : 1'b0;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_setup;
    assign rd_setup = setup_phase && !pwrite;

    // Aligned, mapped read in its setup cycle
    logic rd_ok;
    assign rd_ok = rd_setup && req_mapped;

    chk_all_lock_and: assert property (
        rd_setup && req_idx == prsb_pkg::IDX_LOCK && paddr[1:0] == 2'b00
        |=> prdata[prsb_pkg::LK_ALL] ==
            ($past(loop_status.analog_lock) && $past(loop_status.dig_phase_lock)))
        else $error("channel lock is not analog and phase lock");

    chk_live_locks: assert property (
        rd_setup && req_idx == prsb_pkg::IDX_LOCK && paddr[1:0] == 2'b00
        |=> prdata[prsb_pkg::LK_ALOCK] == $past(loop_status.analog_lock)
            && prdata[prsb_pkg::LK_FLOCK] == $past(loop_status.dig_freq_lock)
            && prdata[prsb_pkg::LK_PLOCK] == $past(loop_status.dig_phase_lock)
            && prdata[7:6] == 2'b00)
        else $error("lock byte does not show live lock state");

    chk_cal_done_hold: assert property (
        cal_complete ##1 (!cal_issue)[*3] |=> st_r.cal_done)
        else $error("calibration done dropped without new calibration");

    chk_cal_busy_span: assert property (
        cal_issue && !cal_complete |=> st_r.cal_busy && !st_r.cal_done)
        else $error("calibration busy not raised on calibration start");

    chk_cal_busy_hold: assert property (
        st_r.cal_busy && !cal_complete |=> st_r.cal_busy)
        else $error("calibration busy dropped before completion");

    chk_cal_busy_idle: assert property (
        !st_r.cal_busy && !cal_issue |=> !st_r.cal_busy)
        else $error("calibration busy rose without a calibration");

    chk_cal_done_clear: assert property (
        cal_issue && !cal_complete |=> !st_r.cal_done)
        else $error("calibration done not cleared by new calibration");

    chk_cal_busy_end: assert property (
        cal_complete && !cal_issue |=> !st_r.cal_busy && st_r.cal_done)
        else $error("calibration busy did not end on completion");

    chk_snap_stable: assert property (
        !io_update && st_r.primed |=> $stable(st_r.snap))
        else $error("snapshot changed without update");

    chk_tw_top_byte: assert property (
        rd_setup && req_idx == prsb_pkg::IDX_TW5 && paddr[1:0] == 2'b00
        |=> prdata[7:0] == {2'b00, $past(st_r.snap.tuning_hist[45:40])})
        else $error("tuning history top byte wrong");

    chk_pld_high: assert property (
        rd_setup && req_idx == prsb_pkg::IDX_PLD_HI && paddr[1:0] == 2'b00
        |=> prdata[7:0] == {4'h0, $past(st_r.snap.pld_accum[11:8])})
        else $error("phase detector high byte wrong");

    chk_profile_keep: assert property (
        io_update && !loop_status.dig_active
        |=> st_r.snap.profile == $past(st_r.held_profile))
        else $error("inactive snapshot lost last profile");

    chk_write_zero: assert property (
        setup_phase && pwrite |=> prdata == prsb_pkg::RD_ZERO && $stable(st_r.snap.tuning_hist))
        else $error("write produced data or changed snapshot");

    chk_reset_prime: assert property (
        !st_r.primed |=> st_r.primed && st_r.snap.tuning_hist == $past(loop_status.tuning_hist))
        else $error("snapshot not loaded after reset");

    chk_analog_bit: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_LOCK
        |=> prdata[prsb_pkg::LK_ALOCK] == $past(loop_status.analog_lock))
        else $error("analog loop lock bit wrong");

    chk_freq_bit: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_LOCK
        |=> prdata[prsb_pkg::LK_FLOCK] == $past(loop_status.dig_freq_lock))
        else $error("frequency lock bit wrong");

    chk_phase_bit: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_LOCK
        |=> prdata[prsb_pkg::LK_PLOCK] == $past(loop_status.dig_phase_lock))
        else $error("phase lock bit wrong");

    chk_tw_low_byte: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_TW0
        |=> prdata == {24'h00_0000, $past(st_r.snap.tuning_hist[7:0])})
        else $error("tuning history low byte wrong");

    chk_pld_low: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_PLD_LO
        |=> prdata == {24'h00_0000, $past(st_r.snap.pld_accum[7:0])})
        else $error("phase detector low byte wrong");

    chk_fld_low: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_FLD_LO
        |=> prdata == {24'h00_0000, $past(st_r.snap.fld_accum[7:0])})
        else $error("frequency detector low byte wrong");

    chk_fld_high: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_FLD_HI
        |=> prdata == {28'h000_0000, $past(st_r.snap.fld_accum[11:8])})
        else $error("frequency detector high byte wrong");

    chk_slew_active: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_SLEW_ACT
        |=> prdata == {31'h0000_0000, $past(st_r.snap.slew_active)})
        else $error("slew active register wrong");

    chk_snap_update: assert property (
        io_update |=> st_r.snap.tuning_hist == $past(loop_status.tuning_hist)
            && st_r.snap.pld_accum == $past(loop_status.pld_accum))
        else $error("snapshot not taken on update");

    chk_profile_track: assert property (
        io_update && loop_status.dig_active
        |=> st_r.snap.profile == $past(loop_status.profile))
        else $error("active snapshot lost current profile");

    chk_oper_flags: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_OPER
        |=> prdata[prsb_pkg::OP_ACTIVE] == $past(st_r.snap.dig_active)
            && prdata[prsb_pkg::OP_REFSW] == $past(st_r.snap.ref_switch)
            && prdata[prsb_pkg::OP_HOLD] == $past(st_r.snap.holdover)
            && prdata[prsb_pkg::OP_FREERUN] == $past(st_r.snap.freerun)
            && prdata[7] == 1'b0)
        else $error("operation flags wrong");

    chk_unmapped_err: assert property (
        setup_phase && !req_mapped |=> pslverr && prdata == prsb_pkg::RD_ZERO)
        else $error("unmapped access not refused");

    chk_mapped_ok: assert property (
        setup_phase && req_mapped |=> !pslverr)
        else $error("mapped access flagged as error");

    chk_slew_err_rsvd: assert property (
        rd_ok && req_idx == prsb_pkg::IDX_SLEW_ERR |=> prdata[31:4] == 28'h000_0000)
        else $error("slew error reserved bits not zero");

    chk_ready_high: assert property (
        psel && penable |-> pready)
        else $error("access phase stalled");

    cov_lock_read:  cover property (rd_setup && req_idx == prsb_pkg::IDX_LOCK ##1 pready);
    cov_cal_cycle:  cover property (cal_issue ##[1:20] cal_complete);
    cov_update_rd:  cover property (io_update ##1 rd_setup && req_idx == prsb_pkg::IDX_TW0);
    cov_bad_addr:   cover property (setup_phase ##1 pslverr);

endmodule

// >>> dv/prsb_status_bank_bench.sv
// Purpose: Self-checking bench for the channel 0 loop status readback bank
// Assumes: Zero-wait APB slave; cal and update strobes are one-cycle pulses
// Notes:   Snapshot bytes are judged against the loop state held at the last io_update
`timescale 1ns/1ps

module prsb_status_bank_bench;
    logic                        pclk = 1'b0;
    logic                        presetn = 1'b0;
    logic                        psel = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite = 1'b0;
    logic [15:0]                 paddr = 16'h0000;
    logic [31:0]                 pwdata = 32'h0000_0000;
    logic [3:0]                  pstrb = 4'h0;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    prsb_pkg::prsb_loop_status_t ls;
    logic                        cal_issue = 1'b0;
    logic                        cal_complete = 1'b0;
    logic                        io_update = 1'b0;
    logic                        exp_busy = 1'b0;
    logic                        exp_done = 1'b0;
    int                          fail_count = 0;
    int                          total_checks = 0;
    int                          cycles = 0;

    prsb_status_bank u_prsb_status_bank (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .loop_status  (ls),
        .cal_issue    (cal_issue),
        .cal_complete (cal_complete),
        .io_update    (io_update)
    );

    always #4 pclk = ~pclk;

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("wrong value at %0t: run hung", $time);
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, output logic [31:0] d,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= 32'hffff_ffff;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1, "no ready");
        end
    endtask

    task automatic rd_chk(input logic [13:0] i, input logic [7:0] exp, input string what);
        logic [31:0] d;
        logic        e;
        apb(1'b0, {i, 2'b00}, d, e);
        check(d, {24'h000000, exp}, what);
        check({31'h0, e}, 32'h0, "error flag on mapped read");
    endtask

    task automatic pulse(input int w);
        @(posedge pclk);
        case (w)
            0: cal_issue <= 1'b1;
            1: cal_complete <= 1'b1;
            default: io_update <= 1'b1;
        endcase
        @(posedge pclk);
        cal_issue <= 1'b0;
        cal_complete <= 1'b0;
        io_update <= 1'b0;
    endtask

    function automatic prsb_pkg::prsb_loop_status_t mk(input logic [7:0] k);
        prsb_pkg::prsb_loop_status_t s;
        s = '0;
        {s.analog_lock, s.dig_freq_lock, s.dig_phase_lock} = k[2:0];
        {s.dig_active, s.ref_switch, s.holdover, s.freerun} = {1'b1, k[3], k[4], k[5]};
        s.profile = k[2:0];
        {s.fast_acquire_done, s.fast_acquire_active} = k[7:6];
        {s.slew_limit, s.freq_clamp, s.hist_avail} = {k[1], k[3], k[5]};
        s.tuning_hist = {k[5:0], k, ~k, k + 8'h11, k ^ 8'h5a, k + 8'h01};
        s.pld_accum = {k[3:0], ~k};
        s.fld_accum = {~k[7:4], k};
        s.slew_active = k[6];
        s.slew_err = k[7:4];
        return s;
    endfunction

    function automatic logic [7:0] lock_byte(input prsb_pkg::prsb_loop_status_t l);
        return {2'b00, exp_done, exp_busy, l.analog_lock, l.dig_freq_lock, l.dig_phase_lock,
                l.analog_lock & l.dig_phase_lock};
    endfunction

    function automatic logic [7:0] snap_byte(input prsb_pkg::prsb_loop_status_t s,
                                             input logic [13:0] i, input logic [2:0] p);
        logic [47:0] tw;
        tw = {2'b00, s.tuning_hist};
        case (i)
            prsb_pkg::IDX_OPER: return {1'b0, p, s.dig_active, s.ref_switch, s.holdover,
                                        s.freerun};
            prsb_pkg::IDX_STATE: return {2'b00, s.fast_acquire_done, s.fast_acquire_active,
                                         1'b0, s.slew_limit, s.freq_clamp, s.hist_avail};
            prsb_pkg::IDX_PLD_LO: return s.pld_accum[7:0];
            prsb_pkg::IDX_PLD_HI: return {4'h0, s.pld_accum[11:8]};
            prsb_pkg::IDX_FLD_LO: return s.fld_accum[7:0];
            prsb_pkg::IDX_FLD_HI: return {4'h0, s.fld_accum[11:8]};
            prsb_pkg::IDX_SLEW_ACT: return {7'h00, s.slew_active};
            prsb_pkg::IDX_SLEW_ERR: return {4'h0, s.slew_err};
            default: return tw[8 * (i - prsb_pkg::IDX_TW0) +: 8];
        endcase
    endfunction

    task automatic chk_all(input prsb_pkg::prsb_loop_status_t s, input logic [2:0] p,
                           input prsb_pkg::prsb_loop_status_t l);
        rd_chk(prsb_pkg::IDX_LOCK, lock_byte(l), "live lock byte");
        for (logic [13:0] i = 14'h3101; i <= 14'h310e; i++) begin
            rd_chk(i, snap_byte(s, i, p), "snapshot byte");
        end
    endtask

    task automatic t_lock_live();
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            ls <= mk(8'(i));
            rd_chk(prsb_pkg::IDX_LOCK, lock_byte(mk(8'(i))), "lock bits");
        end
    endtask

    task automatic t_cal();
        pulse(0);
        exp_busy = 1'b1;
        exp_done = 1'b0;
        rd_chk(prsb_pkg::IDX_LOCK, lock_byte(ls), "busy while calibrating");
        pulse(1);
        exp_busy = 1'b0;
        exp_done = 1'b1;
        repeat (20) @(posedge pclk);
        rd_chk(prsb_pkg::IDX_LOCK, lock_byte(ls), "done holds");
        pulse(0);
        exp_busy = 1'b1;
        exp_done = 1'b0;
        rd_chk(prsb_pkg::IDX_LOCK, lock_byte(ls), "done cleared by new cal");
        pulse(1);
        exp_busy = 1'b0;
        exp_done = 1'b1;
    endtask

    task automatic t_snapshot();
        logic [7:0] ks [4] = '{8'h5a, 8'ha5, 8'hc3, 8'h0f};
        foreach (ks[j]) begin
            @(posedge pclk);
            ls <= mk(ks[j]);
            pulse(2);
            ls <= mk(~ks[j]);
            chk_all(mk(ks[j]), ks[j][2:0], mk(~ks[j]));
        end
    endtask

    task automatic t_profile();
        prsb_pkg::prsb_loop_status_t s;
        s = mk(8'h5a);
        s.profile = 3'h5;
        @(posedge pclk);
        ls <= s;
        pulse(2);
        s.dig_active = 1'b0;
        s.profile = 3'h2;
        ls <= s;
        pulse(2);
        chk_all(s, 3'h5, s);
    endtask

    task automatic t_read_only();
        logic [15:0] bad [3] = '{16'hc43c, 16'hc406, 16'hc3fc};
        logic [31:0] d;
        logic        e;
        @(posedge pclk);
        ls <= mk(8'h69);
        pulse(2);
        for (logic [13:0] i = 14'h3100; i <= 14'h310e; i++) begin
            apb(1'b1, {i, 2'b00}, d, e);
            check({31'h0, e}, 32'h0, "error flag on write");
        end
        chk_all(mk(8'h69), 3'h1, mk(8'h69));
        foreach (bad[j]) begin
            apb(1'b0, bad[j], d, e);
            check(d, 32'h0, "unmapped data");
            check({31'h0, e}, 32'h1, "unmapped error flag");
        end
    endtask

    initial begin
        ls = mk(8'h3c);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk_all(mk(8'h3c), 3'h4, mk(8'h3c));
        t_lock_live();
        t_cal();
        t_snapshot();
        t_profile();
        t_read_only();
        give_verdict();
    end
endmodule
